/* File: core/spmp_top.sv */
`timescale 1ns/1ns
`include "spmp_consts.svh"
// Notes on behaviour
// - Pins drive LCD segments until software sets the port enable.
// - Select high holds serial state at its reset values; access address and prefetch byte keep theirs.
// - Select high: output floats, clock and data input ignored.
// - Transaction starts on first rising clock after select falls.
// - Host ends by raising select; device closes and flags interrupt.
// - Read returns addressed bytes for as long as host clocks.
// - Access address adds one after every byte read or written.
// - Command-only transaction is still a complete transaction.
// - Command and address captured for processor, latest kept.
// - Captured address never follows the auto-incremented address.
// - Flag set at every end, whatever the command code.
// - Hardware only sets flag; processor clears it writing zero.
// - Sixteen-bit address reaches whole external data memory space.
// - Command top bits 11 means read from given address.
// - Command top bits 10 means write from given address.
// - Top bit 0: no memory access, interrupt still raised.
module spmp_top import spmp_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [3:0] lcd_seg_i,
	input wire logic [3:0] seg_pin_i,
	output logic [3:0] seg_pin_o,
	output logic [3:0] seg_pin_oe_o,
	output spmp_mem_s mem_o,
	input wire logic mem_ack_i,
	input wire logic [7:0] mem_rdata_i,
	output logic serial_irq_o
);
	// ****************************************
	// Pin synchronisers and edge detection
	// ****************************************
	spmp_link_s lk;
	logic sclk_d_reg;
	logic en;
	logic csn_eff;
	logic rise;
	logic fall;

	spmp_sync #(.W(3)) u_sync (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.async_i({seg_pin_i[0], seg_pin_i[1], seg_pin_i[2]}),
		.sync_o(lk)
	);

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sclk_d_reg <= 1'b1;
		end else begin
			sclk_d_reg <= lk.sclk;
		end
	end

	// Disabled or deselected port sees no edges
	assign csn_eff = lk.csn | ~en;
	assign rise = lk.sclk & ~sclk_d_reg & ~csn_eff;
	assign fall = ~lk.sclk & sclk_d_reg & ~csn_eff;

	// ****************************************
	// Serial frame engine
	// ****************************************
	spmp_state_e state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [15:0] rx_reg, rx_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [15:0] acc_reg, acc_next;
	logic [7:0] tx_reg, tx_next;
	logic [7:0] pre_reg, pre_next;
	logic [7:0] cap_cmd_reg, cap_cmd_next;
	logic [15:0] cap_addr_reg, cap_addr_next;
	spmp_mem_s mem_reg, mem_next;
	logic [15:0] rx_sh;
	logic is_rd;
	logic is_wr;
	logic mem_issue;
	logic flag_set;
	logic flag;

	// MSB first, high address byte arrives first
	assign rx_sh = {rx_reg[14:0], lk.sdi};
	// Read code, top bit 0 never accesses
	assign is_rd = cmd_reg[7:6] == `SPMP_RD_CODE;
	assign is_wr = cmd_reg[7:6] == `SPMP_WR_CODE;
	// Close on select rise, flag any frame
	assign flag_set = csn_eff & (state_reg != SPMP_IDLE);

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		rx_next = rx_reg;
		cmd_next = cmd_reg;
		acc_next = acc_reg;
		tx_next = tx_reg;
		pre_next = pre_reg;
		cap_cmd_next = cap_cmd_reg;
		cap_addr_next = cap_addr_reg;
		mem_next = mem_reg;
		mem_issue = 1'b0;
		if (mem_ack_i) begin
			mem_next.req = 1'b0;
		end
		if (mem_ack_i & mem_reg.req & ~mem_reg.we) begin
			pre_next = mem_rdata_i;
		end
		if (csn_eff) begin
			// Hold reset state; a pending memory cycle still ends
			state_next = SPMP_IDLE;
			cnt_next = 4'h0;
			rx_next = 16'h0000;
			cmd_next = 8'h00;
			tx_next = 8'h00;
		end else if (rise) begin
			rx_next = rx_sh;
			cnt_next = cnt_reg + 4'h1;
			case (state_reg)
				SPMP_IDLE: begin
					// First rising edge opens the command
					state_next = SPMP_CMD;
					cnt_next = 4'h1;
				end
				SPMP_CMD: begin
					if (cnt_reg == `SPMP_CMD_LAST) begin
						cmd_next = rx_sh[7:0];
						cap_cmd_next = rx_sh[7:0];
						state_next = SPMP_ADDR;
						cnt_next = 4'h0;
					end
				end
				SPMP_ADDR: begin
					if (cnt_reg == `SPMP_ADDR_LAST) begin
						// Capture address as sent, never stepped
						cap_addr_next = rx_sh;
						acc_next = rx_sh;
						state_next = SPMP_DATA;
						cnt_next = 4'h0;
						if (is_rd) begin
							mem_issue = 1'b1;
							mem_next.we = 1'b0;
							mem_next.addr = rx_sh;
						end
					end
				end
				SPMP_DATA: begin
					if (cnt_reg == `SPMP_DATA_LAST) begin
						cnt_next = 4'h0;
						if (is_wr) begin
							mem_issue = 1'b1;
							mem_next.we = 1'b1;
							mem_next.addr = acc_reg;
							mem_next.wdata = rx_sh[7:0];
						end
					end
				end
				default: begin
					state_next = SPMP_IDLE;
				end
			endcase
		end else if (fall && state_reg == SPMP_DATA && is_rd) begin
			if (cnt_reg == 4'h0) begin
				// Next byte loads and the one after is fetched
				tx_next = pre_reg;
				mem_issue = 1'b1;
				mem_next.we = 1'b0;
				mem_next.addr = acc_reg;
			end else begin
				tx_next = {tx_reg[6:0], 1'b0};
			end
		end
		// Full 16-bit reach, no register window excluded here
		if (mem_issue) begin
			mem_next.req = 1'b1;
			// Step the access address per byte
			acc_next = mem_next.addr + `SPMP_ADDR_STEP;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= SPMP_IDLE;
			cnt_reg <= 4'h0;
			rx_reg <= 16'h0000;
			cmd_reg <= 8'h00;
			acc_reg <= 16'h0000;
			tx_reg <= 8'h00;
			pre_reg <= 8'h00;
			cap_cmd_reg <= `SPMP_RST_CMD;
			cap_addr_reg <= `SPMP_RST_ADDR;
			mem_reg <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			rx_reg <= rx_next;
			cmd_reg <= cmd_next;
			acc_reg <= acc_next;
			tx_reg <= tx_next;
			pre_reg <= pre_next;
			cap_cmd_reg <= cap_cmd_next;
			cap_addr_reg <= cap_addr_next;
			mem_reg <= mem_next;
		end
	end

	assign mem_o = mem_reg;

	// ****************************************
	// Pin sharing with LCD segments
	// ****************************************
	// LCD drive until enabled
	assign seg_pin_o = en ? {tx_reg[7], 3'h0} : lcd_seg_i;
	assign seg_pin_oe_o = en ? {~csn_eff, 3'h0} : 4'hF;

	// ****************************************
	// Register slave
	// ****************************************
	spmp_avs u_avs (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o),
		.flag_set_i(flag_set),
		.cap_cmd_i(cap_cmd_reg),
		.cap_addr_i(cap_addr_reg),
		.enable_o(en),
		.flag_o(flag)
	);

	assign serial_irq_o = flag;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_cmd_done;
		rise && state_reg == SPMP_CMD && cnt_reg == `SPMP_CMD_LAST;
	endsequence

	sequence s_addr_done;
		rise && state_reg == SPMP_ADDR && cnt_reg == `SPMP_ADDR_LAST;
	endsequence

	sequence s_byte_done;
		rise && state_reg == SPMP_DATA && cnt_reg == `SPMP_DATA_LAST;
	endsequence

	a_lcd_default: assert property (
		!en |-> seg_pin_oe_o == 4'hF && seg_pin_o == lcd_seg_i)
		else $error("segment pins not on LCD while disabled");
	a_idle_hold: assert property (
		csn_eff |=> state_reg == SPMP_IDLE && cnt_reg == 4'h0)
		else $error("serial state not held while deselected");
	a_out_float: assert property (
		en && csn_eff |-> !seg_pin_oe_o[3])
		else $error("serial output driven while deselected");
	a_first_rise: assert property (
		state_reg == SPMP_IDLE && rise |=>
		state_reg == SPMP_CMD && cnt_reg == 4'h1)
		else $error("transaction did not open on first rise");
	a_end_flag: assert property (
		csn_eff && state_reg != SPMP_IDLE |=> ##1 serial_irq_o)
		else $error("no interrupt after select rise");
	a_cmd_only: assert property (
		csn_eff && state_reg == SPMP_ADDR && cnt_reg == 4'h0 |=> flag)
		else $error("command-only transaction not flagged");
	a_cmd_capture: assert property (
		s_cmd_done |=> cap_cmd_reg == $past(rx_sh[7:0]))
		else $error("command not captured");
	a_cap_stable: assert property (
		state_reg == SPMP_DATA |=> cap_addr_reg == $past(cap_addr_reg))
		else $error("captured address moved during data");
	a_any_cmd_flag: assert property (
		csn_eff && state_reg == SPMP_DATA && !cmd_reg[7] |=> ##1 flag)
		else $error("ignored command not flagged");
	a_read_fetch: assert property (
		(s_addr_done and is_rd) |=> mem_reg.req && !mem_reg.we &&
		mem_reg.addr == cap_addr_reg)
		else $error("read fetch not issued after address");
	a_write_issue: assert property (
		(s_byte_done and is_wr) |=> mem_reg.req && mem_reg.we &&
		mem_reg.wdata == $past(rx_sh[7:0]))
		else $error("write byte not issued");
	a_addr_step: assert property (
		mem_issue |=> acc_reg == mem_reg.addr + `SPMP_ADDR_STEP)
		else $error("access address not stepped");
	a_no_access: assert property (
		state_reg == SPMP_DATA && !cmd_reg[7] |-> !mem_issue)
		else $error("memory touched for ignored command");
	a_tx_load: assert property (
		fall && state_reg == SPMP_DATA && is_rd && cnt_reg == 4'h0
		|=> tx_reg == $past(pre_reg))
		else $error("read byte not loaded on falling edge");
	a_tx_rise_hold: assert property (
		rise && state_reg == SPMP_DATA |=> $stable(tx_reg))
		else $error("output changed on rising edge");
endmodule

/* File: core/spmp_consts.svh */
`ifndef SPMP_CONSTS_SVH
`define SPMP_CONSTS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define SPMP_OFS_CTRL 4'h0
`define SPMP_OFS_STAT 4'h4
`define SPMP_OFS_CMD 4'h8
`define SPMP_OFS_ADDR 4'hC
// ****************************************
// Field positions and reset values
// ****************************************
`define SPMP_CTRL_EN_BIT 0
`define SPMP_STAT_FLAG_BIT 0
`define SPMP_RST_EN 1'b0
`define SPMP_RST_FLAG 1'b0
`define SPMP_RST_CMD 8'h00
`define SPMP_RST_ADDR 16'h0000
// ****************************************
// Frame layout
// ****************************************
`define SPMP_CMD_LAST 4'h7
`define SPMP_ADDR_LAST 4'hF
`define SPMP_DATA_LAST 4'h7
`define SPMP_RD_CODE 2'h3
`define SPMP_WR_CODE 2'h2
`define SPMP_ADDR_STEP 16'h0001
`endif

/* File: core/spmp_pkg.sv */
package spmp_pkg;
	typedef enum logic [1:0] {
		SPMP_IDLE = 2'h0,
		SPMP_CMD = 2'h1,
		SPMP_ADDR = 2'h3,
		SPMP_DATA = 2'h2
	} spmp_state_e;

	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} spmp_mem_s;

	typedef struct packed {
		logic csn;
		logic sclk;
		logic sdi;
	} spmp_link_s;
endpackage

/* File: core/spmp_sync.sv */
`timescale 1ns/1ns
module spmp_sync #(
	parameter int W = 3
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			always_ff @(posedge ref_clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					meta_reg[g] <= 1'b1;
					sync_reg[g] <= 1'b1;
				end else begin
					meta_reg[g] <= async_i[g];
					sync_reg[g] <= meta_reg[g];
				end
			end
		end
	endgenerate

	assign sync_o = sync_reg;
endmodule

/* File: core/spmp_avs.sv */
`timescale 1ns/1ns
`include "spmp_consts.svh"
module spmp_avs import spmp_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic flag_set_i,
	input wire logic [7:0] cap_cmd_i,
	input wire logic [15:0] cap_addr_i,
	output logic enable_o,
	output logic flag_o
);
	logic ack_reg, ack_next;
	logic en_reg, en_next;
	logic flag_reg, flag_next;
	logic [31:0] rd_reg, rd_next;
	logic wr_now;

	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
	assign wr_now = avs_write_i & ack_reg;

	always_comb begin
		ack_next = (avs_read_i | avs_write_i) & ~ack_reg;
		en_next = en_reg;
		flag_next = flag_reg;
		rd_next = rd_reg;
		if (avs_read_i & ~ack_reg) begin
			rd_next = 32'h0000_0000;
			if (avs_address_i == `SPMP_OFS_CTRL) begin
				rd_next[`SPMP_CTRL_EN_BIT] = en_reg;
			end else if (avs_address_i == `SPMP_OFS_STAT) begin
				rd_next[`SPMP_STAT_FLAG_BIT] = flag_reg;
			end else if (avs_address_i == `SPMP_OFS_CMD) begin
				rd_next[7:0] = cap_cmd_i;
			end else if (avs_address_i == `SPMP_OFS_ADDR) begin
				rd_next[15:0] = cap_addr_i;
			end
		end
		if (wr_now && avs_address_i == `SPMP_OFS_CTRL) begin
			en_next = avs_writedata_i[`SPMP_CTRL_EN_BIT];
		end
		if (wr_now && avs_address_i == `SPMP_OFS_STAT &&
			!avs_writedata_i[`SPMP_STAT_FLAG_BIT]) begin
			flag_next = 1'b0;
		end
		if (flag_set_i) begin
			flag_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ack_reg <= 1'b0;
			en_reg <= `SPMP_RST_EN;
			flag_reg <= `SPMP_RST_FLAG;
			rd_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= ack_next;
			en_reg <= en_next;
			flag_reg <= flag_next;
			rd_reg <= rd_next;
		end
	end

	assign avs_readdata_o = rd_reg;
	assign enable_o = en_reg;
	assign flag_o = flag_reg;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	a_flag_set_wins: assert property (flag_set_i |=> flag_reg)
		else $error("transaction flag lost on set");
	a_flag_only_sw: assert property (
		$fell(flag_reg) |-> $past(wr_now) && !$past(flag_set_i))
		else $error("transaction flag cleared without write");
endmodule

/* File: verification/spmp_host_model.sv */
`timescale 1ns/1ns
module spmp_host_model import spmp_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic sdo_i,
	output spmp_link_s link_o
);
	initial link_o = '{1'b1, 1'b0, 1'b0};
	// ****
	// One frame of nb bytes, gap before data
	// ****
	task automatic frame(input logic [7:0] tx [8], input int nb,
		input logic gap, output logic [7:0] rx [8]);
		@(posedge ref_clk_i);
		link_o.csn <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		for (int k = 0; k < nb; k++) begin
			if (gap && k == 3) begin
				repeat (16) @(posedge ref_clk_i);
			end
			for (int b = 7; b >= 0; b--) begin
				link_o.sclk <= 1'b0;
				link_o.sdi <= tx[k][b];
				repeat (5) @(posedge ref_clk_i);
				link_o.sclk <= 1'b1;
				rx[k][b] = sdo_i;
				repeat (3) @(posedge ref_clk_i);
			end
		end
		link_o.sclk <= 1'b0;
		link_o.sdi <= ~link_o.sdi;
		repeat (4) @(posedge ref_clk_i);
		link_o.csn <= 1'b1;
		repeat (12) @(posedge ref_clk_i);
	endtask
endmodule

/* File: verification/tb_spi_slave_memory_port.sv */
`timescale 1ns/1ns
`include "spmp_consts.svh"
module tb_spi_slave_memory_port import spmp_pkg::*;;
	logic ref_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [3:0] lcd_seg_i = 4'h0;
	logic [3:0] seg_pin_o;
	logic [3:0] seg_pin_oe_o;
	logic [3:0] pin_lvl;
	spmp_mem_s mem_o;
	logic mem_ack_i = 1'b0;
	logic [7:0] mem_rdata_i = 8'h00;
	logic serial_irq_o;
	spmp_link_s link;
	logic float_p = 1'b0;
	logic [31:0] seed = 32'h0001_1877;
	logic [15:0] last_a = `SPMP_RST_ADDR;
	logic [15:0] wa [$];
	logic [7:0] wd [$];
	int rd_cnt = 0;
	int mismatches = 0;
	int compares = 0;

	always #10 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) float_p <= ~float_p;
	assign pin_lvl = (seg_pin_oe_o & seg_pin_o) |
		(~seg_pin_oe_o & {float_p, link.sdi, link.sclk, link.csn});

	spmp_top u_spmp_top (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .lcd_seg_i(lcd_seg_i),
		.seg_pin_i(pin_lvl), .seg_pin_o(seg_pin_o),
		.seg_pin_oe_o(seg_pin_oe_o), .mem_o(mem_o), .mem_ack_i(mem_ack_i),
		.mem_rdata_i(mem_rdata_i), .serial_irq_o(serial_irq_o));
	spmp_host_model u_spmp_host_model (.ref_clk_i(ref_clk_i),
		.sdo_i(pin_lvl[3]), .link_o(link));

	// ****
	// Memory model and helpers
	// ****
	always @(posedge ref_clk_i) begin
		mem_ack_i <= 1'b0;
		if (mem_o.req && !mem_ack_i) begin
			mem_ack_i <= 1'b1;
			mem_rdata_i <= mem_val(mem_o.addr);
			if (mem_o.we) begin
				wa.push_back(mem_o.addr);
				wd.push_back(mem_o.wdata);
			end else begin
				rd_cnt++;
			end
		end
	end

	function automatic logic [7:0] mem_val(input logic [15:0] a);
		return a[15:8] ^ a[7:0] ^ 8'h5A;
	endfunction

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic we, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] rd);
		int n;
		@(posedge ref_clk_i);
		avs_address_i <= a;
		avs_write_i <= we;
		avs_read_i <= ~we;
		avs_writedata_i <= d;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		rd = avs_readdata_o;
		if (n >= 50) mismatches++;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask

	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] rd;
		bus(1'b1, a, d, rd);
	endtask

	task automatic chkreg(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		bus(1'b0, a, 32'h0, rd);
		chk32(rd, exp);
	endtask

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ****
	// One frame with all its checks
	// ****
	task automatic xfer(input logic [7:0] c, input logic [15:0] a,
		input int nb);
		logic [7:0] tx [8];
		logic [7:0] rx [8];
		logic [31:0] r;
		int w0;
		int r0;
		w0 = wa.size();
		r0 = rd_cnt;
		tx[0] = c;
		tx[1] = a[15:8];
		tx[2] = a[7:0];
		for (int k = 3; k < 8; k++) begin
			r = xs();
			tx[k] = r[7:0];
		end
		u_spmp_host_model.frame(tx, nb, c[7:6] == 2'h3, rx);
		for (int k = 3; k < nb; k++) begin
			if (c[7:6] == 2'h3) begin
				chk8(rx[k], mem_val(a + 16'(k - 3)));
			end else if (c[7:6] == 2'h2) begin
				chk8(wd[w0 + k - 3], tx[k]);
				chk32({16'h0000, wa[w0 + k - 3]},
					{16'h0000, 16'(a + 16'(k - 3))});
			end
		end
		chk32(32'(wa.size() - w0), (c[7:6] == 2'h2 && nb > 3) ?
			32'(nb - 3) : 32'h0);
		if (!c[7]) chk32(32'(rd_cnt - r0), 32'h0);
		if (nb >= 3) last_a = a;
		chkreg(`SPMP_OFS_CMD, {24'h0, c});
		chkreg(`SPMP_OFS_ADDR, {16'h0, last_a});
		chk8({7'h0, serial_irq_o}, 8'h01);
		chkreg(`SPMP_OFS_STAT, 32'h1);
		wreg(`SPMP_OFS_STAT, 32'h1);
		chkreg(`SPMP_OFS_STAT, 32'h1);
		wreg(`SPMP_OFS_STAT, 32'h0);
		chkreg(`SPMP_OFS_STAT, 32'h0);
		chk8({7'h0, serial_irq_o}, 8'h00);
	endtask

	initial begin
		#1_000_000;
		mismatches++;
		tally_and_finish();
	end

	initial begin
		logic [31:0] r;
		logic [7:0] tx_d [8];
		logic [7:0] rx_d [8];
		int nb;
		tx_d = '{default: 8'h80};
		repeat (10) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		chkreg(`SPMP_OFS_CTRL, 32'(`SPMP_RST_EN));
		chkreg(`SPMP_OFS_STAT, 32'(`SPMP_RST_FLAG));
		chkreg(`SPMP_OFS_CMD, 32'(`SPMP_RST_CMD));
		chkreg(`SPMP_OFS_ADDR, 32'(`SPMP_RST_ADDR));
		chkreg(4'h2, 32'h0);
		r = xs();
		lcd_seg_i <= r[3:0];
		repeat (3) @(posedge ref_clk_i);
		chk8({seg_pin_oe_o, seg_pin_o}, {4'hF, lcd_seg_i});
		u_spmp_host_model.frame(tx_d, 4, 1'b0, rx_d);
		chkreg(`SPMP_OFS_STAT, 32'h0);
		chk32(32'(wa.size()), 32'h0);
		wreg(`SPMP_OFS_CTRL, 32'h1);
		chkreg(`SPMP_OFS_CTRL, 32'h1);
		wreg(`SPMP_OFS_STAT, 32'h0);
		wreg(`SPMP_OFS_CMD, 32'hFF);
		chkreg(`SPMP_OFS_CMD, 32'h0);
		chk8({4'h0, seg_pin_oe_o}, 8'h00);
		xfer(8'h80, 16'hFFFF, 6);
		xfer(8'hC0, 16'h0000, 6);
		xfer(8'h3F, 16'h1234, 1);
		xfer(8'h40, 16'h2000, 5);
		xfer(8'hFF, 16'hFFFE, 5);
		xfer(8'hBF, 16'h8000, 4);
		repeat (8) begin
			r = xs();
			nb = int'(r[26:24]);
			if (nb < 3) nb = 1;
			xfer(r[7:0], r[23:8], nb);
		end
		tally_and_finish();
	end
endmodule
